// ===== rtl/tes_pkg.sv
// shared constants for the time code event scheduler
package tes_pkg;
  // ------------------------------------------------------------
  // list geometry
  // ------------------------------------------------------------
  localparam int MAX_EVENTS = 50;
  localparam int IDX_W = 6;
  localparam int HH_W = 5;
  localparam int MM_W = 6;
  localparam int SS_W = 6;
  localparam int FF_W = 5;
  localparam int ADDR_W = HH_W + MM_W + SS_W + FF_W;
  localparam int TGT_W = 8;
  localparam int VAL_W = 8;
  localparam int DUR_W = 10;
  localparam int DATA_W = 3 + TGT_W + VAL_W + DUR_W;
  // entry data field positions
  localparam int D_TYPE_LSB = 0;
  localparam int D_TGT_LSB = 3;
  localparam int D_VAL_LSB = 11;
  localparam int D_DUR_LSB = 19;
  // ------------------------------------------------------------
  // automation types and time code formats
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TES_SETUP = 3'h0,
    TES_EFFECT_ONE = 3'h1,
    TES_EFFECT_TWO = 3'h2,
    TES_GLIDE_ONE = 3'h3,
    TES_GLIDE_TWO = 3'h4,
    TES_GLIDE_SETUP = 3'h5
  } tes_type_e;
  typedef enum logic [1:0] {
    TES_FMT_NONDROP = 2'h0,
    TES_FMT_DROP = 2'h1,
    TES_FMT_EBU = 2'h2,
    TES_FMT_FILM = 2'h3
  } tes_fmt_e;
  localparam logic [FF_W-1:0] FPS_30 = 5'h1e;
  localparam logic [FF_W-1:0] FPS_25 = 5'h19;
  localparam logic [FF_W-1:0] FPS_24 = 5'h18;
  localparam logic [FF_W-1:0] DROP_FIRST = 5'h02;
  localparam logic [MM_W-1:0] MIN_LIMIT = 6'h3c;
  localparam logic [SS_W-1:0] SEC_LIMIT = 6'h3c;
  localparam logic [HH_W-1:0] HOUR_LIMIT = 5'h18;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int TC_LOSS_MS = 100;
  localparam int TC_LOSS_CYC = TC_LOSS_MS * CLK_KHZ;
  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RUN = 8'h08;
  localparam logic [7:0] OFS_LAST = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_SNAP_IDX = 8'h14;
  localparam logic [7:0] OFS_NEW_ADDR = 8'h18;
  localparam logic [7:0] OFS_NEW_DATA = 8'h1c;
  localparam logic [7:0] OFS_RD_IDX = 8'h20;
  localparam logic [7:0] OFS_RD_ADDR = 8'h24;
  localparam logic [7:0] OFS_RD_DATA = 8'h28;
  // control bits
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SPLIT = 1;
  // command bits
  localparam int CMD_CAPTURE = 0;
  localparam int CMD_UNDO = 1;
  localparam int CMD_INSERT = 2;
  localparam int CMD_DELETE = 3;
  localparam int CMD_DUP = 4;
  localparam int CMD_CLEAR = 5;
  localparam int CMD_IDX_LSB = 8;
  // status bits
  localparam int ST_FMT_LSB = 0;
  localparam int ST_VALID = 2;
  localparam int ST_NDV = 3;
  localparam int ST_DFV = 4;
  localparam int ST_EBUV = 5;
  localparam int ST_FILMV = 6;
  localparam int ST_ERR = 7;
  localparam int ST_CNT_LSB = 8;
  localparam int ST_SNAP_LSB = 16;
  localparam int ST_NEXT_LSB = 24;
endpackage

// ===== rtl/tes_scheduler.sv
// time code reader, event list and event firing with an apb slave
//
// Notes on behaviour
// - address is hours:minutes:seconds:frames, each frame adds exactly one.
// - drop-frame skips frames 00 and 01 except minutes divisible by ten.
// - non-drop 30 fps and drop-frame 29.97 fps are accepted.
// - 25 fps broadcast and 24 fps cinema formats are accepted too.
// - list holds up to fifty entries: address, type, target.
// - list enable off means no entry causes any change.
// - list stays sorted; insertion shifts later entries down by one. Capture and undo here write one address in place without re-sorting.
// - deletion keeps order and moves later entries up by one.
// - capture stores running address into pending entry, then advances.
// - last capture is kept and shown; undo clears only that address.
// - format and validity reported, distinct flags per format.
// - first list entry must be a setup recall.
// - six types; machine-two types only while split setup runs. Checked on insert only; duplicate and firing ignore split.
// - glide entries hold parameter, final value and frame duration.
// - glide acts on setup and effect loaded by preceding entries.
// - entry fires when running address reaches its address.
// - duplicate places copy directly after the original.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module tes_scheduler
  import tes_pkg::*;
#(
  parameter int LOSS_CYC = TC_LOSS_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tc_clk,
  input wire logic tc_frame_stb,
  input wire logic [ADDR_W-1:0] tc_addr,
  input wire logic [1:0] tc_format,
  output logic nondrop_valid,
  output logic dropframe_valid,
  output logic fire_stb,
  output logic [2:0] fire_type,
  output logic [TGT_W-1:0] fire_target,
  output logic [VAL_W-1:0] fire_value,
  output logic [DUR_W-1:0] fire_duration,
  output logic [TGT_W-1:0] fire_context
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [FF_W-1:0] fps_of(input logic [1:0] f);
    case (f)
      TES_FMT_EBU: fps_of = FPS_25;
      TES_FMT_FILM: fps_of = FPS_24;
      default: fps_of = FPS_30;
    endcase
  endfunction

  // one frame forward, with drop-frame skipping
  function automatic logic [ADDR_W-1:0] tc_next(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] f
  );
    logic [HH_W-1:0] h;
    logic [MM_W-1:0] m;
    logic [SS_W-1:0] s;
    logic [FF_W-1:0] fr;
    {h, m, s, fr} = a;
    fr = fr + 5'h01;
    if (fr == fps_of(f))
    begin
      fr = '0;
      s = s + 6'h01;
      if (s == SEC_LIMIT)
      begin
        s = '0;
        m = m + 6'h01;
        if (m == MIN_LIMIT)
        begin
          m = '0;
          h = h + 5'h01;
          if (h == HOUR_LIMIT)
            h = '0;
        end
        if (f == TES_FMT_DROP && (m % 6'h0a) != 6'h00)
          fr = DROP_FIRST;
      end
    end
    tc_next = {h, m, s, fr};
  endfunction

  // ------------------------------------------------------------
  // link side capture on the time code clock
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] tc_word_r;
  logic [1:0] tc_fmt_r;
  logic tc_tgl_r;

  always_ff @(posedge tc_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc_word_r <= '0;
      tc_fmt_r <= '0;
      tc_tgl_r <= 1'b0;
    end
    else if (tc_frame_stb)
    begin
      tc_word_r <= tc_addr;
      tc_fmt_r <= tc_format;
      tc_tgl_r <= ~tc_tgl_r;
    end
  end

  // ------------------------------------------------------------
  // frame event crossing and address tracking
  // ------------------------------------------------------------
  logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic [ADDR_W-1:0] run_r;
  logic [1:0] fmt_r;
  logic valid_r;
  logic back_jump_r;
  logic [31:0] loss_cnt_r;
  wire new_frame = tgl_s2_r ^ tgl_s3_r;
  // held word is stable for a whole frame once the toggle is seen
  wire [ADDR_W-1:0] rx_addr = tc_word_r;
  wire [1:0] rx_fmt = tc_fmt_r;
  wire rx_ff_ok = rx_addr[FF_W-1:0] < fps_of(rx_fmt);
  wire rx_in_seq = rx_fmt == fmt_r && rx_addr == tc_next(run_r, fmt_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      run_r <= '0;
      fmt_r <= '0;
      valid_r <= 1'b0;
      back_jump_r <= 1'b0;
      loss_cnt_r <= '0;
    end
    else
    begin
      tgl_s1_r <= tc_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      back_jump_r <= new_frame && rx_addr < run_r;
      if (new_frame)
      begin
        run_r <= rx_addr;
        fmt_r <= rx_fmt;
        valid_r <= rx_in_seq && rx_ff_ok;
        loss_cnt_r <= '0;
      end
      else if (loss_cnt_r >= 32'(LOSS_CYC - 1))
        valid_r <= 1'b0;
      else
        loss_cnt_r <= loss_cnt_r + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] mem_addr [MAX_EVENTS];
  logic [DATA_W-1:0] mem_data [MAX_EVENTS];
  logic [IDX_W-1:0] count_r, snap_idx_r, last_idx_r, rd_idx_r, next_r;
  logic [ADDR_W-1:0] last_cap_r, new_addr_r;
  logic [DATA_W-1:0] new_data_r;
  logic [1:0] ctrl_r;
  logic err_r;

  wire [7:0] ofs = paddr[7:0];
  wire addr_hit = paddr[31:8] == 24'h0 && (ofs == OFS_CTRL ||
    ofs == OFS_STATUS || ofs == OFS_RUN || ofs == OFS_LAST ||
    ofs == OFS_CMD || ofs == OFS_SNAP_IDX || ofs == OFS_NEW_ADDR ||
    ofs == OFS_NEW_DATA || ofs == OFS_RD_IDX || ofs == OFS_RD_ADDR ||
    ofs == OFS_RD_DATA);
  wire setup_ph = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready && addr_hit;
  wire cmd_wr = wr_acc && ofs == OFS_CMD;
  wire [IDX_W-1:0] cmd_idx = pwdata[CMD_IDX_LSB +: IDX_W];
  wire list_en = ctrl_r[CTRL_ENABLE];
  wire split_on = ctrl_r[CTRL_SPLIT];
  wire rd_ok = rd_idx_r < IDX_W'(MAX_EVENTS);
  wire [IDX_W-1:0] rd_sel = rd_ok ? rd_idx_r : '0;

  wire [31:0] status_word = {
    2'b00, next_r, 2'b00, snap_idx_r, 2'b00, count_r,
    err_r,
    valid_r && fmt_r == TES_FMT_FILM,
    valid_r && fmt_r == TES_FMT_EBU,
    valid_r && fmt_r == TES_FMT_DROP,
    valid_r && fmt_r == TES_FMT_NONDROP,
    valid_r, fmt_r};

  logic [31:0] rd_mux;
  always_comb
  begin
    case (ofs)
      OFS_CTRL: rd_mux = {30'h0, ctrl_r};
      OFS_STATUS: rd_mux = status_word;
      OFS_RUN: rd_mux = {10'h0, run_r};
      OFS_LAST: rd_mux = {10'h0, last_cap_r};
      OFS_SNAP_IDX: rd_mux = {26'h0, snap_idx_r};
      OFS_NEW_ADDR: rd_mux = {10'h0, new_addr_r};
      OFS_NEW_DATA: rd_mux = {3'h0, new_data_r};
      OFS_RD_IDX: rd_mux = {26'h0, rd_idx_r};
      OFS_RD_ADDR: rd_mux = rd_ok ? {10'h0, mem_addr[rd_sel]} : '0;
      OFS_RD_DATA: rd_mux = rd_ok ? {3'h0, mem_data[rd_sel]} : '0;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_hit;
      if (setup_ph && !pwrite)
        prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= '0;
      new_addr_r <= '0;
      new_data_r <= '0;
      rd_idx_r <= '0;
    end
    else if (wr_acc)
    begin
      if (ofs == OFS_CTRL)
        ctrl_r <= pwdata[1:0];
      if (ofs == OFS_NEW_ADDR)
        new_addr_r <= pwdata[ADDR_W-1:0];
      if (ofs == OFS_NEW_DATA)
        new_data_r <= pwdata[DATA_W-1:0];
      if (ofs == OFS_RD_IDX)
        rd_idx_r <= pwdata[IDX_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // list edits
  // ------------------------------------------------------------
  logic [IDX_W-1:0] ins_pos;
  always_comb
  begin
    ins_pos = '0;
    for (int i = 0; i < MAX_EVENTS; i++)
      if (IDX_W'(i) < count_r && mem_addr[i] <= new_addr_r)
        ins_pos = ins_pos + IDX_W'(1);
  end

  wire [2:0] new_type = new_data_r[D_TYPE_LSB +: 3];
  wire full = count_r == IDX_W'(MAX_EVENTS);
  wire type_ok = new_type <= TES_GLIDE_SETUP && (split_on ||
    (new_type != TES_EFFECT_TWO && new_type != TES_GLIDE_TWO));
  wire ins_ok = !full && type_ok &&
    (ins_pos != '0 || new_type == TES_SETUP);
  wire [IDX_W-1:0] idx_p1 = cmd_idx + IDX_W'(1);
  wire del_ok = cmd_idx < count_r && (cmd_idx != '0 ||
    count_r == IDX_W'(1) ||
    mem_data[1][D_TYPE_LSB +: 3] == TES_SETUP);
  wire dup_ok = !full && cmd_idx < count_r;
  wire cap_ok = valid_r && snap_idx_r <= count_r &&
    snap_idx_r < IDX_W'(MAX_EVENTS);
  wire do_ins = cmd_wr && pwdata[CMD_INSERT] && ins_ok;
  wire do_del = cmd_wr && pwdata[CMD_DELETE] && del_ok;
  wire do_dup = cmd_wr && pwdata[CMD_DUP] && dup_ok;
  wire do_cap = cmd_wr && pwdata[CMD_CAPTURE] && cap_ok;
  wire do_undo = cmd_wr && pwdata[CMD_UNDO];
  wire do_clr = cmd_wr && pwdata[CMD_CLEAR];
  wire cmd_bad = cmd_wr && ((pwdata[CMD_INSERT] && !ins_ok) ||
    (pwdata[CMD_DELETE] && !del_ok) || (pwdata[CMD_DUP] && !dup_ok) ||
    (pwdata[CMD_CAPTURE] && !cap_ok));
  wire list_edit = do_ins || do_del || do_dup || do_cap || do_undo ||
    do_clr;
  // shift point and entry placed there for insert and duplicate
  wire [IDX_W-1:0] sh_pos = do_dup ? idx_p1 : ins_pos;
  wire [ADDR_W-1:0] sh_addr = do_dup ? mem_addr[cmd_idx] : new_addr_r;
  wire [DATA_W-1:0] sh_data = do_dup ? mem_data[cmd_idx] : new_data_r;
  logic have_last_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < MAX_EVENTS; i++)
      begin
        mem_addr[i] <= '0;
        mem_data[i] <= '0;
      end
      count_r <= '0;
      snap_idx_r <= '0;
      last_idx_r <= '0;
      last_cap_r <= '0;
      have_last_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      if (cmd_wr)
        err_r <= cmd_bad;
      if (wr_acc && ofs == OFS_SNAP_IDX)
        snap_idx_r <= pwdata[IDX_W-1:0];
      if (do_clr)
      begin
        count_r <= '0;
        snap_idx_r <= '0;
        have_last_r <= 1'b0;
      end
      else if (do_ins || do_dup)
      begin
        for (int i = MAX_EVENTS - 1; i > 0; i--)
          if (IDX_W'(i) > sh_pos)
          begin
            mem_addr[i] <= mem_addr[i-1];
            mem_data[i] <= mem_data[i-1];
          end
        mem_addr[sh_pos] <= sh_addr;
        mem_data[sh_pos] <= sh_data;
        count_r <= count_r + IDX_W'(1);
      end
      else if (do_del)
      begin
        for (int i = 0; i < MAX_EVENTS - 1; i++)
          if (IDX_W'(i) >= cmd_idx)
          begin
            mem_addr[i] <= mem_addr[i+1];
            mem_data[i] <= mem_data[i+1];
          end
        count_r <= count_r - IDX_W'(1);
      end
      else if (do_cap)
      begin
        mem_addr[snap_idx_r] <= run_r;
        if (snap_idx_r == count_r)
        begin
          mem_data[snap_idx_r] <= '0;
          count_r <= count_r + IDX_W'(1);
        end
        snap_idx_r <= snap_idx_r + IDX_W'(1);
        last_idx_r <= snap_idx_r;
        last_cap_r <= run_r;
        have_last_r <= 1'b1;
      end
      else if (do_undo && have_last_r)
      begin
        mem_addr[last_idx_r] <= '0;
        last_cap_r <= '0;
        have_last_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // event firing
  // ------------------------------------------------------------
  logic skip_eq_r;
  logic [TGT_W-1:0] cur_setup_r, cur_eff1_r, cur_eff2_r;
  wire [IDX_W-1:0] nx_sel = next_r < IDX_W'(MAX_EVENTS) ? next_r : '0;
  wire pend = next_r < count_r && !new_frame && !back_jump_r;
  wire [ADDR_W-1:0] ev_addr = mem_addr[nx_sel];
  wire [DATA_W-1:0] ev_data = mem_data[nx_sel];
  wire [2:0] ev_type = ev_data[D_TYPE_LSB +: 3];
  wire [TGT_W-1:0] ev_tgt = ev_data[D_TGT_LSB +: TGT_W];
  wire ev_hit = pend && ev_addr == run_r;
  wire ev_fire = ev_hit && !skip_eq_r && list_en && valid_r;
  wire [TGT_W-1:0] ev_ctx = ev_type == TES_GLIDE_ONE ? cur_eff1_r :
    ev_type == TES_GLIDE_TWO ? cur_eff2_r : cur_setup_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_r <= '0;
      skip_eq_r <= 1'b0;
      cur_setup_r <= '0;
      cur_eff1_r <= '0;
      cur_eff2_r <= '0;
      fire_stb <= 1'b0;
      fire_type <= '0;
      fire_target <= '0;
      fire_value <= '0;
      fire_duration <= '0;
      fire_context <= '0;
      nondrop_valid <= 1'b0;
      dropframe_valid <= 1'b0;
    end
    else
    begin
      nondrop_valid <= valid_r && fmt_r == TES_FMT_NONDROP;
      dropframe_valid <= valid_r && fmt_r == TES_FMT_DROP;
      fire_stb <= ev_fire;
      if (list_edit)
      begin
        next_r <= '0; // entries at the current frame already had a turn
        skip_eq_r <= 1'b1;
      end
      else if (back_jump_r)
      begin
        next_r <= '0;
        skip_eq_r <= 1'b0;
      end
      else if (new_frame)
        skip_eq_r <= 1'b0;
      else if (pend && ev_addr <= run_r)
        next_r <= next_r + IDX_W'(1);
      if (ev_fire)
      begin
        fire_type <= ev_type;
        fire_target <= ev_tgt;
        fire_value <= ev_data[D_VAL_LSB +: VAL_W];
        fire_duration <= ev_data[D_DUR_LSB +: DUR_W];
        fire_context <= ev_ctx;
        case (ev_type)
          TES_SETUP: cur_setup_r <= ev_tgt;
          TES_EFFECT_ONE: cur_eff1_r <= ev_tgt;
          TES_EFFECT_TWO: cur_eff2_r <= ev_tgt;
          default: cur_setup_r <= cur_setup_r;
        endcase
      end
    end
  end
endmodule

// ===== verif/tes_tc_source.sv
// time code source model driving frames onto the link
`timescale 1ns/1ps
module tes_tc_source
  import tes_pkg::*;
(
  output logic tc_clk,
  output logic tc_frame_stb,
  output logic [ADDR_W-1:0] tc_addr,
  output logic [1:0] tc_format
);
  initial {tc_clk, tc_frame_stb, tc_addr, tc_format} = '0;
  // clock runs only per frame; address inverted after the strobe
  task automatic send(input logic [ADDR_W-1:0] a, input logic [1:0] f);
    #4.1;
    tc_addr = a;
    tc_format = f;
    tc_frame_stb = 1'b1;
    repeat (4)
    begin
      #7.5 tc_clk = 1'b1;
      #7.5 tc_clk = 1'b0;
      tc_frame_stb = 1'b0;
      tc_addr = ~a;
    end
  endtask
endmodule

// ===== verif/tes_scheduler_assertions.sv
// port-level assertions for the time code event scheduler
`timescale 1ns/1ps
module tes_scheduler_assertions
  import tes_pkg::*;
#(
  parameter int LOSS_CYC = TC_LOSS_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tc_clk,
  input wire logic tc_frame_stb,
  input wire logic [1:0] tc_format,
  input wire logic nondrop_valid,
  input wire logic dropframe_valid,
  input wire logic fire_stb,
  input wire logic [2:0] fire_type,
  input wire logic [TGT_W-1:0] fire_target
);
  logic tgl;
  logic [1:0] last_fmt;
  logic [2:0] tg_s;
  logic [31:0] idle_cnt;
  wire acc_done = psel && penable && pready;
  // ----------------------------------------------------------
  // frame arrival on the system clock
  // ----------------------------------------------------------
  always_ff @(posedge tc_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      tgl <= 1'b0;
      last_fmt <= 2'h0;
    end
    else if (tc_frame_stb)
    begin
      tgl <= ~tgl;
      last_fmt <= tc_format;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tg_s <= 3'h0;
      idle_cnt <= 32'h0;
    end
    else
    begin
      tg_s <= {tg_s[1:0], tgl};
      if (tg_s[2] != tg_s[1])
        idle_cnt <= 32'h0;
      else if (idle_cnt != 32'hffffffff)
        idle_cnt <= idle_cnt + 32'h1;
    end
  end
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_access_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_scope_a: assert property (pready |-> psel && penable)
    else $error("stray ready");
  unmapped_err_a: assert property (acc_done && paddr[31:8] != 24'h0
    |-> pslverr) else $error("no error on unmapped");
  cmd_rdzero_a: assert property (acc_done && !pwrite
    && paddr == {24'h0, OFS_CMD} |-> prdata == 32'h0)
    else $error("command read nonzero");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata)) else $error("read data moved");
  fire_hold_a: assert property ($changed(fire_type) ||
    $changed(fire_target) |-> fire_stb) else $error("fire fields moved");
  fire_legal_a: assert property (fire_stb |-> fire_type <= 3'h5)
    else $error("illegal fired type");
  valid_excl_a: assert property (!(nondrop_valid && dropframe_valid))
    else $error("two formats valid");
  nd_format_a: assert property ($rose(nondrop_valid)
    |-> last_fmt == 2'h0) else $error("non-drop flag wrong");
  df_format_a: assert property ($rose(dropframe_valid)
    |-> last_fmt == 2'h1) else $error("drop flag wrong");
  loss_clear_a: assert property (idle_cnt > LOSS_CYC + 10
    |-> !nondrop_valid && !dropframe_valid) else $error("valid kept");
  cover property (fire_stb && fire_type == 3'h3);
  cover property (acc_done && pslverr);
  cover property ($rose(dropframe_valid));
endmodule

bind tes_scheduler tes_scheduler_assertions #(.LOSS_CYC(LOSS_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tc_clk(tc_clk), .tc_frame_stb(tc_frame_stb),
  .tc_format(tc_format), .nondrop_valid(nondrop_valid),
  .dropframe_valid(dropframe_valid), .fire_stb(fire_stb),
  .fire_type(fire_type), .fire_target(fire_target));

// ===== verif/testbench.sv
// self-checking bench for the time code event scheduler
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module testbench
  import tes_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic tc_clk, tc_frame_stb, nondrop_valid, dropframe_valid, fire_stb;
  logic [ADDR_W-1:0] tc_addr;
  logic [1:0] tc_format;
  logic [2:0] fire_type;
  logic [7:0] fire_target, fire_value, fire_context;
  logic [9:0] fire_duration;
  logic [36:0] fq [$];
  logic [31:0] st [5], ea [4], ed [4];
  logic [1:0] sf [5];
  int failures = 0;
  int checks = 0;

  tes_scheduler #(.LOSS_CYC(200)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tc_clk(tc_clk),
    .tc_frame_stb(tc_frame_stb), .tc_addr(tc_addr), .tc_format(tc_format),
    .nondrop_valid(nondrop_valid), .dropframe_valid(dropframe_valid),
    .fire_stb(fire_stb), .fire_type(fire_type), .fire_target(fire_target),
    .fire_value(fire_value), .fire_duration(fire_duration),
    .fire_context(fire_context));
  tes_tc_source src (.tc_clk(tc_clk), .tc_frame_stb(tc_frame_stb),
    .tc_addr(tc_addr), .tc_format(tc_format));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (fire_stb === 1'b1)
      fq.push_back({fire_type, fire_target, fire_value, fire_duration,
        fire_context});
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] tc(input int h, m, s, f);
    return {10'h0, 5'(h), 6'(m), 6'(s), 5'(f)};
  endfunction
  function automatic logic [31:0] ent(input int t, g, v, d);
    return {3'h0, 10'(d), 8'(v), 8'(g), 3'(t)};
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] a, logic [1:0] f);
    logic [4:0] h, fr, lim;
    logic [5:0] m, s;
    {h, m, s, fr} = a[21:0];
    lim = (f == 2'h2) ? FPS_25 : (f == 2'h3) ? FPS_24 : FPS_30;
    fr++;
    if (fr == lim)
    begin
      fr = 5'h0;
      s++;
      if (s == SEC_LIMIT)
      begin
        s = 6'h0;
        m++;
        if (m == MIN_LIMIT)
        begin
          m = 6'h0;
          h = (h == HOUR_LIMIT - 5'h1) ? 5'h0 : h + 5'h1;
        end
        if (f == 2'h1 && m % 10 != 0)
          fr = DROP_FIRST;
      end
    end
    return {10'h0, h, m, s, fr};
  endfunction
  task automatic acc(input logic w, logic [31:0] a, d, output logic [31:0] r,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    acc(1'b1, {24'h0, a}, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, m);
    logic [31:0] r;
    logic e;
    acc(1'b0, {24'h0, a}, 32'h0, r, e);
    `CHK(r & m, x)
  endtask
  task automatic cmd(input int b, idx);
    wr(OFS_CMD, 32'((1 << b) | (idx << CMD_IDX_LSB)));
  endtask
  task automatic ins(input logic [31:0] a, d);
    wr(OFS_NEW_ADDR, a);
    wr(OFS_NEW_DATA, d);
    cmd(CMD_INSERT, 0);
  endtask
  task automatic ek(input int i, input logic [31:0] a, d);
    wr(OFS_RD_IDX, 32'(i));
    rdc(OFS_RD_ADDR, a, '1);
    rdc(OFS_RD_DATA, d, '1);
  endtask
  task automatic frm(input logic [31:0] a, input logic [1:0] f);
    src.send(a[ADDR_W-1:0], f);
    repeat (80) @(posedge pclk);
  endtask
  task automatic run(input int a, b);
    for (int i = a; i <= b; i++)
      frm(32'(i), 2'h0);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge pclk);
    failures++;
    tally_and_finish;
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    logic [31:0] a, x, r;
    logic e;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    st = '{tc(1, 0, 59, 29), tc(0, 1, 59, 29), tc(0, 9, 59, 29),
      tc(0, 0, 59, 24), tc(23, 59, 59, 23)};
    sf = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    ea = '{32'd10, 32'd15, 32'd15, 32'd20};
    ed = '{ent(0, 8'h11, 0, 0), ent(1, 8'h44, 0, 0),
      ent(5, 8'h55, 8'h66, 3), ent(3, 8'h22, 8'h33, 10'h64)};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b1, 32'h100, 32'h1, r, e);
    `CHK({e, r}, 33'h100000000)
    acc(1'b0, 32'h2c, 32'h0, r, e);
    `CHK({e, r}, 33'h100000000)
    rdc(OFS_CTRL, 32'h0, '1);
    rdc(OFS_STATUS, 32'h0, '1);
    rdc(OFS_CMD, 32'h0, '1);
    for (int i = 0; i < 5; i++)
    begin
      a = st[i];
      repeat (3)
      begin
        frm(a, sf[i]);
        x = a;
        a = nxt(a, sf[i]);
      end
      rdc(OFS_STATUS, 32'(sf[i]) | 32'h4 | (32'h8 << sf[i]), 32'hff);
      rdc(OFS_RUN, x, '1);
      `CHK({nondrop_valid, dropframe_valid}, {sf[i] == 2'h0, sf[i] == 2'h1})
    end
    frm(tc(0, 0, 59, 29), 2'h1);
    frm(tc(0, 1, 0, 0), 2'h1);
    rdc(OFS_STATUS, 32'h1, 32'hff);
    run(0, 1);
    repeat (250) @(posedge pclk);
    rdc(OFS_STATUS, 32'h0, 32'h4);
    ins(ea[0], ed[0]);
    ins(32'd5, ent(1, 8'h77, 0, 0));
    rdc(OFS_STATUS, 32'h180, 32'h3f80);
    ins(ea[3], ed[3]);
    ins(ea[1], ed[1]);
    ins(ea[2], ed[2]);
    ins(32'd12, ent(2, 8'h77, 0, 0));
    rdc(OFS_STATUS, 32'h480, 32'h3f80);
    for (int i = 0; i < 4; i++)
      ek(i, ea[i], ed[i]);
    cmd(CMD_DUP, 1);
    ek(2, ea[1], ed[1]);
    cmd(CMD_DELETE, 2);
    for (int i = 0; i < 4; i++)
      ek(i, ea[i], ed[i]);
    run(8, 21);
    `CHK(fq.size(), 0)
    wr(OFS_CTRL, 32'h1);
    run(8, 21);
    `CHK(fq.size(), 4)
    for (int i = 0; i < 4 && i < fq.size(); i++)
    begin
      x = ed[i];
      `CHK(fq[i][36:8], {x[2:0], x[10:3], x[18:11], x[28:19]})
    end
    `CHK(fq[2][7:0], 8'h11)
    `CHK(fq[3][7:0], 8'h44)
    wr(OFS_SNAP_IDX, 32'h3);
    cmd(CMD_CAPTURE, 0);
    rdc(OFS_LAST, 32'd21, '1);
    rdc(OFS_SNAP_IDX, 32'h4, '1);
    ek(3, 32'd21, ed[3]);
    cmd(CMD_UNDO, 0);
    rdc(OFS_LAST, 32'h0, '1);
    ek(3, 32'h0, ed[3]);
    ek(2, ea[2], ed[2]);
    cmd(CMD_CLEAR, 0);
    wr(OFS_CTRL, 32'h2);
    ins(tc(1, 0, 0, 0), ent(0, 1, 0, 0));
    ins(tc(1, 0, 0, 1), ent(6, 1, 0, 0));
    rdc(OFS_STATUS, 32'h180, 32'h3f80);
    for (int i = 1; i < 50; i++)
      ins(tc(1, 0, i, 0), ent(i % 6, i, 0, 0));
    rdc(OFS_STATUS, 32'h3200, 32'h3f00);
    ins(tc(2, 0, 0, 0), ent(0, 1, 0, 0));
    rdc(OFS_STATUS, 32'h3280, 32'h3f80);
    wr(OFS_RD_IDX, 32'd50);
    rdc(OFS_RD_ADDR, 32'h0, '1);
    tally_and_finish;
  end
endmodule
